/* File: design/pfi_defs.svh */
// Offsets, field positions and reset values of the pseudo-fault injection registers
`ifndef PFI_DEFS_SVH
`define PFI_DEFS_SVH

`define PFI_FEAT_OFS      16'h0800
`define PFI_CTL_OFS       16'h0808
`define PFI_CDN_OFS       16'h0810
`define PFI_REC_STRIDE    16'h0040

`define PFI_CTL_CNT_EN    31
`define PFI_CTL_RESTART   30
`define PFI_CTL_MV        12
`define PFI_CTL_CE_HI     7
`define PFI_CTL_CE_LO     6
`define PFI_CTL_DE        5
`define PFI_CTL_UEO       4
`define PFI_CTL_UER       3
`define PFI_CTL_UEU       2
`define PFI_CTL_UC        1
`define PFI_CTL_OVF       0

`define PFI_FEAT_RESTART  30
`define PFI_FEAT_SYN      29
`define PFI_FEAT_MV       12

`define PFI_INJ_NONE_CAP  2'h0
`define PFI_CTL_RESET     11'h000
`define PFI_CDN_RESET     32'h0000_0000

`endif

/* File: design/pfi_pkg.sv */
// Types shared by the pseudo-fault injection control logic
`default_nettype none
package pfi_pkg;

  typedef enum logic [2:0] {
    INJ_NONE,
    INJ_CE,
    INJ_DE,
    INJ_UEO,
    INJ_UER,
    INJ_UEU,
    INJ_UC
  } inj_kind_type;

  typedef struct packed {
    logic       cnt_en;
    logic       restart;
    logic       mv;
    logic [1:0] ce;
    logic       de;
    logic       latent_fault_en;
    logic       recoverable_fault_en;
    logic       fatal_fault_en;
    logic       uc;
    logic       ovf;
  } ctl_type;

  typedef struct packed {
    logic         valid;
    inj_kind_type kind;
    logic [1:0]   ce_code;
    logic         ovf;
    logic         misc_valid;
    logic         misc_log;
    logic         code_load;
  } inj_rec_type;

endpackage : pfi_pkg
`default_nettype wire

/* File: design/pseudo_fault_injection_ctl.sv */
// Pseudo-fault injection control: control, countdown and feature registers
`timescale 1ns/100ps
`default_nettype none
`include "pfi_defs.svh"

// Behaviour
// (R1) Corrected select: 01 logs code 10, 10 logs 01, 11 logs 11, 00 none.
// (R2) Software programs corrected select only with encodings the feature field permits.
// (R3) Deferred error may fire at zero only when postponed enable set.
// (R4) Latent error may fire at zero only when latent enable set.
// (R5) Recoverable error may fire at zero only when recoverable enable set.
// (R6) Unrecoverable error may fire at zero only when fatal enable set.
// (R7) Uncontainable error may fire at zero only when uncontainable enable set.
// (R8) Deferred and uncorrected types may be dropped when data is not consumed.
// (R9) Recorded overflow flag equals the overflow inject value bit.
// (R10) Unsupported control fields read zero and ignore writes.
// (R11) Cold reset sets fields; error-recovery reset preserves them.
// (R12) Feature register is 64-bit read-only, zero unless injection present, first record.
// (R13) Feature register at 0x800 plus 64 times n; writes ignored.
// (R14) Feature restart bit reads one when restart control is implemented.
// (R15) Syndrome cap zero loads codes; one keeps them, writable while record invalid.
// (R16) Misc cap zero: logging any misc syndrome sets misc-valid.
// (R17) Misc cap one: copy control misc-valid, or log, set one, control reads one.
// (R18) Unupdated misc fields keep contents, writable while misc-valid is zero.
// (R19) Feature bits 63:31 and 28:13 read zero.
// (R20) Enabled nonzero counter decrements each cycle; at zero injects an enabled type.
// (R21) Writing enable one loads counter from reload value; zero disables.
// (R22) At zero, counter reloads when restart set, otherwise stops.
// (R23) No type enabled injects nothing; several enabled inject exactly one.
module pseudo_fault_injection_ctl #(
  parameter int         REC_IDX         = 0,     // Record number n
  parameter bit         FIRST_REC       = 1'b1,  // Record is the node's first
  parameter logic [1:0] INJ_CAP         = 2'h1,  // Injection capability
  parameter int         CNT_W           = 32,    // Counter width
  parameter logic [1:0] SUP_CE          = 2'h3,  // Corrected capability
  parameter bit         SUP_DE          = 1'b1,  // Deferred supported
  parameter bit         SUP_UEO         = 1'b1,  // Latent supported
  parameter bit         SUP_UER         = 1'b1,  // Recoverable supported
  parameter bit         SUP_UEU         = 1'b1,  // Unrecoverable supported
  parameter bit         SUP_UC          = 1'b1,  // Uncontainable supported
  parameter bit         SUP_OVF         = 1'b1,  // Overflow control supported
  parameter bit         SUP_RESTART     = 1'b1,  // Restart control supported
  parameter bit         SYN_CAP         = 1'b0,  // Codes kept on injection
  parameter bit         MV_CAP          = 1'b1,  // Misc syndrome controllable
  parameter bit         MV_ALWAYS       = 1'b0,  // Always logs misc syndrome
  parameter bit         MV_LOG          = 1'b0,  // Logs misc when not controllable
  parameter bit         FIRE_UNCONSUMED = 1'b1   // Fire unconsumed uncorrected types
) (
  input  wire logic                 i_clk,            // Node clock
  input  wire logic                 i_sys_rst,        // Cold reset
  input  wire logic                 i_er_rst,         // Error-recovery reset
  input  wire logic [15:0]          i_reg_addr,       // Register byte offset
  input  wire logic                 i_reg_wr,         // Write strobe
  input  wire logic                 i_reg_rd,         // Read strobe
  input  wire logic [63:0]          i_reg_wdata,      // Write data
  output logic [63:0]               o_reg_rdata,      // Read data
  input  wire logic                 i_data_consumed,  // Affected data consumed
  input  wire logic                 i_status_v,       // Record valid flag
  input  wire logic                 i_status_mv,      // Record misc-valid flag
  output pfi_pkg::inj_rec_type      o_rec,            // Injected error to record
  output logic                      o_code_wr_allow,  // Error codes writable
  output logic                      o_misc_wr_allow   // Unupdated misc fields writable
);
  import pfi_pkg::*;

  localparam bit          PRESENT  = (INJ_CAP != `PFI_INJ_NONE_CAP) && FIRST_REC;
  localparam logic [15:0] REC_BASE = 16'(REC_IDX * 64);
  localparam logic [15:0] FEAT_A   = `PFI_FEAT_OFS + REC_BASE;
  localparam logic [15:0] CTL_A    = `PFI_CTL_OFS + REC_BASE;
  localparam logic [15:0] CDN_A    = `PFI_CDN_OFS + REC_BASE;

  ctl_type            ctl_q;
  logic [CNT_W-1:0]   cdn_q;
  logic [CNT_W-1:0]   cnt_q;
  inj_rec_type        rec_q;
  logic [63:0]        rdata_q;
  logic               wr_ctl;
  logic               wr_cdn;
  logic               zero_evt;
  logic               fire;
  inj_kind_type       sel;
  ctl_type            ctl_rd;
  logic [63:0]        feat_word;

  function automatic logic [1:0] ce_code(input logic [1:0] sel_ce);
    case (sel_ce)
      2'h1:    ce_code = 2'h2;
      2'h2:    ce_code = 2'h1;
      2'h3:    ce_code = 2'h3;
      default: ce_code = 2'h0;
    endcase
  endfunction : ce_code

  // Drops fields the node does not implement
  function automatic ctl_type supported(input ctl_type c);
    ctl_type m;
    m         = c;
    m.restart = c.restart & SUP_RESTART;
    m.mv      = c.mv & MV_CAP;
    m.ce      = (SUP_CE == 2'h0) ? 2'h0 : c.ce;
    m.de      = c.de & SUP_DE;
    m.latent_fault_en     = c.latent_fault_en & SUP_UEO;
    m.recoverable_fault_en     = c.recoverable_fault_en & SUP_UER;
    m.fatal_fault_en     = c.fatal_fault_en & SUP_UEU;
    m.uc      = c.uc & SUP_UC;
    m.ovf     = c.ovf & SUP_OVF;
    return m;
  endfunction : supported

  function automatic ctl_type from_word(input logic [63:0] w);
    ctl_type c;
    c.cnt_en  = w[`PFI_CTL_CNT_EN];
    c.restart = w[`PFI_CTL_RESTART];
    c.mv      = w[`PFI_CTL_MV];
    c.ce      = w[`PFI_CTL_CE_HI:`PFI_CTL_CE_LO];
    c.de      = w[`PFI_CTL_DE];
    c.latent_fault_en     = w[`PFI_CTL_UEO];
    c.recoverable_fault_en     = w[`PFI_CTL_UER];
    c.fatal_fault_en     = w[`PFI_CTL_UEU];
    c.uc      = w[`PFI_CTL_UC];
    c.ovf     = w[`PFI_CTL_OVF];
    return c;
  endfunction : from_word

  function automatic logic [63:0] to_word(input ctl_type c);
    logic [63:0] w;
    w                                  = 64'h0;
    w[`PFI_CTL_CNT_EN]                 = c.cnt_en;
    w[`PFI_CTL_RESTART]                = c.restart;
    w[`PFI_CTL_MV]                     = c.mv;
    w[`PFI_CTL_CE_HI:`PFI_CTL_CE_LO]   = c.ce;
    w[`PFI_CTL_DE]                     = c.de;
    w[`PFI_CTL_UEO]                    = c.latent_fault_en;
    w[`PFI_CTL_UER]                    = c.recoverable_fault_en;
    w[`PFI_CTL_UEU]                    = c.fatal_fault_en;
    w[`PFI_CTL_UC]                     = c.uc;
    w[`PFI_CTL_OVF]                    = c.ovf;
    return w;
  endfunction : to_word

  // Writes are dropped during error-recovery reset so contents survive it
  assign wr_ctl = PRESENT && i_reg_wr && !i_er_rst && (i_reg_addr == CTL_A);
  assign wr_cdn = PRESENT && i_reg_wr && !i_er_rst && (i_reg_addr == CDN_A);

  // Feature word; reserved bits stay zero
  always_comb begin
    feat_word = 64'h0;                                                      // [R19]
    if (PRESENT) begin                                                      // [R12]
      feat_word[`PFI_FEAT_RESTART]              = SUP_RESTART;              // [R14]
      feat_word[`PFI_FEAT_SYN]                  = SYN_CAP;                  // [R15]
      feat_word[`PFI_FEAT_MV]                   = MV_CAP;                   // [R17]
      feat_word[`PFI_CTL_CE_HI:`PFI_CTL_CE_LO]  = SUP_CE;
      feat_word[`PFI_CTL_DE]                    = SUP_DE;
      feat_word[`PFI_CTL_UEO]                   = SUP_UEO;
      feat_word[`PFI_CTL_UER]                   = SUP_UER;
      feat_word[`PFI_CTL_UEU]                   = SUP_UEU;
      feat_word[`PFI_CTL_UC]                    = SUP_UC;
      feat_word[`PFI_CTL_OVF]                   = SUP_OVF;
    end
  end

  always_comb begin
    ctl_rd    = ctl_q;
    ctl_rd.mv = (MV_CAP && MV_ALWAYS) ? 1'b1 : ctl_q.mv;                    // [R17]
  end

  // Control register; cold reset picks zero for undefined fields
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctl_q <= `PFI_CTL_RESET;                                              // [R11]
    end else if (wr_ctl) begin
      ctl_q <= supported(from_word(i_reg_wdata));                           // [R10]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cdn_q <= CNT_W'(`PFI_CDN_RESET);
    end else if (wr_cdn) begin
      cdn_q <= i_reg_wdata[CNT_W-1:0];
    end
  end

  // Generation counter, hidden from software
  assign zero_evt = ctl_q.cnt_en && (cnt_q == CNT_W'(1));                   // [R20]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (wr_ctl) begin
      cnt_q <= i_reg_wdata[`PFI_CTL_CNT_EN] ? cdn_q : '0;                   // [R21]
    end else if (zero_evt) begin
      cnt_q <= ctl_q.restart ? cdn_q : '0;                                  // [R22]
    end else if (ctl_q.cnt_en && (cnt_q != '0)) begin
      cnt_q <= cnt_q - CNT_W'(1);                                           // [R20]
    end
  end

  // Most severe enabled type wins
  always_comb begin
    if (ctl_q.uc) begin
      sel = INJ_UC;                                                         // [R7]
    end else if (ctl_q.fatal_fault_en) begin
      sel = INJ_UEU;                                                        // [R6]
    end else if (ctl_q.recoverable_fault_en) begin
      sel = INJ_UER;                                                        // [R5]
    end else if (ctl_q.latent_fault_en) begin
      sel = INJ_UEO;                                                        // [R4]
    end else if (ctl_q.de) begin
      sel = INJ_DE;                                                         // [R3]
    end else if (ctl_q.ce != 2'h0) begin
      sel = INJ_CE;                                                         // [R1]
    end else begin
      sel = INJ_NONE;                                                       // [R23]
    end
  end

  assign fire = zero_evt && (sel != INJ_NONE)                               // [R23]
                && ((sel == INJ_CE) || FIRE_UNCONSUMED || i_data_consumed); // [R8]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rec_q <= '0;
    end else begin
      rec_q.valid     <= fire;
      rec_q.kind      <= fire ? sel : INJ_NONE;
      rec_q.ce_code   <= (fire && sel == INJ_CE) ? ce_code(ctl_q.ce) : 2'h0;  // [R1]
      rec_q.ovf       <= fire && ctl_q.ovf;                                 // [R9]
      rec_q.misc_valid <= fire && (MV_CAP ? (MV_ALWAYS || ctl_q.mv) : MV_LOG);  // [R16] [R17]
      rec_q.misc_log  <= fire && (MV_CAP ? MV_ALWAYS : MV_LOG);             // [R16]
      rec_q.code_load <= fire && !SYN_CAP;                                  // [R15]
    end
  end

  // Read port; feature register ignores writes by having no storage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 64'h0;
    end else if (i_reg_rd) begin
      if (PRESENT && i_reg_addr == FEAT_A) begin
        rdata_q <= feat_word;                                               // [R13]
      end else if (PRESENT && i_reg_addr == CTL_A) begin
        rdata_q <= to_word(ctl_rd);
      end else if (PRESENT && i_reg_addr == CDN_A) begin
        rdata_q <= 64'(cdn_q);
      end else begin
        rdata_q <= 64'h0;
      end
    end
  end

  assign o_reg_rdata     = rdata_q;
  assign o_rec           = rec_q;
  assign o_code_wr_allow = SYN_CAP && !i_status_v;                          // [R15]
  assign o_misc_wr_allow = MV_CAP && !i_status_mv;                          // [R18]

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_ce_fire;
    zero_evt && sel == INJ_CE;
  endsequence

  sequence s_ce_logged;
    o_rec.valid && o_rec.kind == INJ_CE && o_rec.ce_code == ce_code($past(ctl_q.ce));
  endsequence

  property p_ce_map;
    s_ce_fire |=> s_ce_logged;
  endproperty
  a_ce_map: assert property (p_ce_map) else $error("corrected code wrong"); // [R1]

  property p_de_gate;
    o_rec.valid && o_rec.kind == INJ_DE |-> $past(ctl_q.de);
  endproperty
  a_de_gate: assert property (p_de_gate) else $error("deferred not enabled"); // [R3]

  property p_ueo_gate;
    !ctl_q.latent_fault_en ##1 o_rec.valid |-> o_rec.kind != INJ_UEO;
  endproperty
  a_ueo_gate: assert property (p_ueo_gate) else $error("latent not enabled"); // [R4]

  property p_uer_gate;
    zero_evt && ctl_q.recoverable_fault_en && !ctl_q.uc && !ctl_q.fatal_fault_en && fire |=> o_rec.kind == INJ_UER;
  endproperty
  a_uer_gate: assert property (p_uer_gate) else $error("recoverable missed"); // [R5]

  property p_ueu_gate;
    o_rec.kind == INJ_UEU |-> $past(ctl_q.fatal_fault_en) && !$past(ctl_q.uc);
  endproperty
  a_ueu_gate: assert property (p_ueu_gate) else $error("fatal not enabled"); // [R6]

  property p_uc_first;
    zero_evt && ctl_q.uc && fire |=> o_rec.valid && o_rec.kind == INJ_UC;
  endproperty
  a_uc_first: assert property (p_uc_first) else $error("uncontainable missed"); // [R7]

  property p_ovf_copy;
    o_rec.valid |-> o_rec.ovf == $past(ctl_q.ovf);
  endproperty
  a_ovf_copy: assert property (p_ovf_copy) else $error("overflow flag wrong"); // [R9]

  property p_none;
    zero_evt && sel == INJ_NONE |=> !o_rec.valid;
  endproperty
  a_none: assert property (p_none) else $error("injected with none enabled"); // [R23]

  sequence s_load;
    wr_ctl && i_reg_wdata[`PFI_CTL_CNT_EN];
  endsequence

  property p_load;
    s_load |=> cnt_q == $past(cdn_q) && ctl_q.cnt_en;
  endproperty
  a_load: assert property (p_load) else $error("counter not loaded"); // [R21]

  property p_dec;
    !wr_ctl && ctl_q.cnt_en && cnt_q > CNT_W'(1) |=> cnt_q == $past(cnt_q) - CNT_W'(1);
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not decrement"); // [R20]

  property p_restart;
    zero_evt && !wr_ctl |=> cnt_q == ($past(ctl_q.restart) ? $past(cdn_q) : '0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart behaviour wrong"); // [R22]

  property p_feat_rsv;
    i_reg_rd && i_reg_addr == FEAT_A |=> o_reg_rdata[63:31] == '0 && o_reg_rdata[28:13] == '0;
  endproperty
  a_feat_rsv: assert property (p_feat_rsv) else $error("reserved feature bits set"); // [R19]

endmodule : pseudo_fault_injection_ctl
`default_nettype wire

/* File: testbench/pseudo_fault_injection_ctl_bench.sv */
// Self-checking bench for the pseudo-fault injection control block
`timescale 1ns/100ps
`default_nettype none
module pseudo_fault_injection_ctl_bench;
  import pfi_pkg::*;

  typedef struct packed {
    logic [63:0]  ctl;
    logic         fire;
    inj_kind_type kind;
    logic [1:0]   code;
  } row_type;

  logic        i_clk;
  logic        i_sys_rst;
  logic        i_er_rst;
  logic [15:0] i_reg_addr;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [63:0] i_reg_wdata;
  logic [63:0] o_reg_rdata;
  logic        i_data_consumed;
  logic        i_status_v;
  logic        i_status_mv;
  inj_rec_type o_rec;
  logic        o_code_wr_allow;
  logic        o_misc_wr_allow;
  int          bad_count;
  int          n_checks;
  row_type     rows [10];
  inj_rec_type exp_rec;
  logic [63:0] rd;
  int          gap;

  pseudo_fault_injection_ctl u_dut (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_er_rst        (i_er_rst),
    .i_reg_addr      (i_reg_addr),
    .i_reg_wr        (i_reg_wr),
    .i_reg_rd        (i_reg_rd),
    .i_reg_wdata     (i_reg_wdata),
    .o_reg_rdata     (o_reg_rdata),
    .i_data_consumed (i_data_consumed),
    .i_status_v      (i_status_v),
    .i_status_mv     (i_status_mv),
    .o_rec           (o_rec),
    .o_code_wr_allow (o_code_wr_allow),
    .o_misc_wr_allow (o_misc_wr_allow)
  );

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_rec(input inj_rec_type got, input inj_rec_type exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rec

  task automatic reg_wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, output logic [63:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
  endtask : reg_rd

  // Cycles until a record pulse, or -1 if none within 20
  task automatic wait_rec(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_rec.valid !== 1'b1 && n < 20);
    if (o_rec.valid !== 1'b1) n = -1;
  endtask : wait_rec

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    #500_000;
    bad_count++;
    final_report();
  end

  initial begin
    bad_count       = 0;
    n_checks        = 0;
    i_sys_rst       = 1'b1;
    i_er_rst        = 1'b0;
    i_reg_addr      = 16'h0000;
    i_reg_wr        = 1'b0;
    i_reg_rd        = 1'b0;
    i_reg_wdata     = 64'h0;
    i_data_consumed = 1'b0;
    i_status_v      = 1'b0;
    i_status_mv     = 1'b0;
    rows[0] = '{64'h0080, 1'b1, INJ_CE, 2'h1};
    rows[1] = '{64'h0081, 1'b1, INJ_CE, 2'h1};
    rows[2] = '{64'h10C0, 1'b1, INJ_CE, 2'h3};
    rows[3] = '{64'h0020, 1'b1, INJ_DE, 2'h0};
    rows[4] = '{64'h1011, 1'b1, INJ_UEO, 2'h0};
    rows[5] = '{64'h0008, 1'b1, INJ_UER, 2'h0};
    rows[6] = '{64'h0004, 1'b1, INJ_UEU, 2'h0};
    rows[7] = '{64'h0002, 1'b1, INJ_UC, 2'h0};
    rows[8] = '{64'h103F, 1'b1, INJ_UC, 2'h0};
    rows[9] = '{64'h1001, 1'b0, INJ_NONE, 2'h0};
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;

    // One injection per row except the last, data never consumed
    foreach (rows[i]) begin
      reg_wr(16'h0810, 64'h3);
      reg_wr(16'h0808, rows[i].ctl | 64'h8000_0000);
      wait_rec(gap);
      exp_rec = '0;
      if (rows[i].fire) begin
        exp_rec.valid      = 1'b1;
        exp_rec.kind       = rows[i].kind;
        exp_rec.ce_code    = rows[i].code;
        exp_rec.ovf        = rows[i].ctl[0];
        exp_rec.misc_valid = rows[i].ctl[12];
        exp_rec.code_load  = 1'b1;
      end
      chk_rec(o_rec, exp_rec);
      @(negedge i_clk);
      chk_data({63'h0, o_rec.valid}, 64'h0);
    end
    $display("injection table done");

    reg_rd(16'h0808, rd);
    chk_data(rd, 64'h8000_1001);
    reg_wr(16'h0808, 64'h0);
    reg_rd(16'h0808, rd);
    chk_data(rd, 64'h0);
    reg_rd(16'h0810, rd);
    chk_data(rd, 64'h3);
    reg_rd(16'h0800, rd);
    chk_data(rd & ~64'h0F00, 64'h4000_10FF);
    reg_wr(16'h0800, 64'h0);
    reg_rd(16'h0800, rd);
    chk_data(rd & ~64'h0F00, 64'h4000_10FF);
    reg_rd(16'h0818, rd);
    chk_data(rd, 64'h0);
    $display("feature register done");

    // Counter loaded with zero must stay silent
    reg_wr(16'h0810, 64'h0);
    reg_wr(16'h0808, 64'hFFFF_FFFF_FFFF_FFFF);
    wait_rec(gap);
    chk_data(gap, -1);
    reg_rd(16'h0808, rd);
    chk_data(rd, 64'h0000_0000_C000_10FF);
    reg_wr(16'h0810, 64'hFFFF_FFFF_FFFF_FFFF);
    reg_rd(16'h0810, rd);
    chk_data(rd, 64'h0000_0000_FFFF_FFFF);
    $display("control readback done");

    // Restart: pulses every load-value cycles, then disable stops them
    reg_wr(16'h0810, 64'h4);
    reg_wr(16'h0808, 64'hC000_0002);
    wait_rec(gap);
    wait_rec(gap);
    chk_data(gap, 4);
    wait_rec(gap);
    chk_data(gap, 4);
    reg_wr(16'h0808, 64'h0);
    wait_rec(gap);
    chk_data(gap, -1);
    $display("restart done");

    // Error-recovery reset keeps contents and blocks writes
    reg_wr(16'h0808, 64'h1005);
    @(posedge i_clk);
    i_er_rst <= 1'b1;
    reg_wr(16'h0808, 64'h0);
    i_er_rst <= 1'b0;
    reg_rd(16'h0808, rd);
    chk_data(rd, 64'h1005);
    $display("recovery reset done");

    for (int v = 0; v < 4; v++) begin
      @(posedge i_clk);
      i_status_v  <= v[0];
      i_status_mv <= v[1];
      @(negedge i_clk);
      chk_data({62'h0, o_code_wr_allow, o_misc_wr_allow}, {63'h0, ~v[1]});
    end
    $display("write permission done");

    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reg_rd(16'h0808, rd);
    chk_data(rd, 64'h0);
    $display("cold reset done");
    final_report();
  end
endmodule : pseudo_fault_injection_ctl_bench
`default_nettype wire
